// File: src/shsr_pkg.sv
// Package for the home-seek and sense-report command block.
// Assumes a task-file style front end that delivers one command byte per strobe.
package shsr_pkg;
    // Command codes.
    localparam logic [3:0] CMD_HOME_NIBBLE      = 4'h1;
    localparam logic [7:0] CMD_SENSE_REPORT     = 8'h0B;
    localparam logic [7:0] CMD_NO_SENSE_UPDATE  = 8'hC3;
    // Error register bit positions.
    localparam int ERR_MARK_MISSING_BIT         = 0;
    localparam int ERR_TRACK_ZERO_MISSING_BIT   = 1;
    localparam int ERR_ABORTED_BIT              = 2;
    localparam int ERR_SECTOR_ID_MISSING_BIT    = 4;
    localparam int ERR_UNCORRECTABLE_BIT        = 6;
    // Status register bit positions.
    localparam int STS_ERROR_BIT                = 0;
    localparam int STS_SENSE_AVAILABLE_BIT      = 1;
    localparam int STS_CORRECTED_BIT            = 2;
    localparam int STS_SEEK_COMPLETE_BIT        = 4;
    localparam int STS_DEVICE_FAULT_BIT         = 5;
    localparam int STS_READY_BIT                = 6;
    localparam int STS_BUSY_BIT                 = 7;
    // Identify word bit that enables sense reporting.
    localparam int IDENT_SENSE_BIT              = 6;
    // Reset values and the home cylinder.
    localparam logic [7:0]  ERR_RESET           = 8'h00;
    localparam logic [7:0]  STS_RESET           = 8'h40;
    localparam logic [19:0] TRIPLET_RESET       = 20'h0_0000;
    localparam logic [15:0] CYL_ZERO            = 16'h0000;
    // Default seek timeout, in clock cycles.
    localparam int SEEK_TIMEOUT_CYCLES          = 1000;

    typedef enum logic [1:0] {
        SHSR_IDLE  = 2'b00,
        SHSR_SEEK  = 2'b01,
        SHSR_DONE  = 2'b10
    } shsr_state_t;
endpackage

// File: src/shsr_flag_hold.sv
// Holding flag whose hardware set wins over a clear.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module shsr_flag_hold (
    // Clock and reset.
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Set and clear.
    input  wire logic i_set,
    input  wire logic i_clr,
    // Flag.
    output logic      o_flag
);
    logic flag_reg;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flag_reg <= 1'b0;
        end else if (i_set) begin
            flag_reg <= 1'b1;
        end else if (i_clr) begin
            flag_reg <= 1'b0;
        end
    end
    assign o_flag = flag_reg;
endmodule // shsr_flag_hold

// File: src/shsr_core.sv
// Command block for the home-seek and sense-report commands.
// Assumes the command byte and outcome inputs are synchronous to i_clk and that the
// servo reports cylinder position and failure on plain inputs.
// Function
// R01: Home-seek command, upper nibble one, drives heads back to cylinder zero.
// R02: Home-seek that fails to reach cylinder zero sets track-zero-missing error bit.
// R03: Sense-report command 0Bh returns the most recent stored sense triplet.
// R04: Qualifier in sector number, code in cylinder low, key in cylinder high.
// R05: With nothing pending, sense-report returns all-zero key, code and qualifier.
// R06: Executing sense-report discards the stored triplet.
// R07: Stored triplet follows latest executed command, except command C3.
// R08: Any later command overwrites the stored triplet with its own outcome.
// R09: Sense-report ignores whether queued automatic sense is configured.
// R10: Queued errors reported; aborts in abort state leave queued triplet alone.
// R11: Sense-report invalidates non-queued log sense content; host must not rely.
// R12: Sense-available status set after sense data, only if both identify bits set.
// R13: With either identify bit clear, sense-available bit is meaningless to host.
// R14: Error and sense-available status bits may both be set at completion.
// R15: Sense reporting feature starts disabled after reset until host enables it.
// R16: On completion clear busy and fault, set error bit if any error flag set.
`timescale 1ns/100ps
module shsr_core #(
    parameter int SEEK_TIMEOUT = shsr_pkg::SEEK_TIMEOUT_CYCLES
) (
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Command strobe from the task file.
    input  wire logic        i_cmd_valid,
    input  wire logic [7:0]  i_cmd_code,
    // Outcome of other commands, reported by the rest of the device.
    input  wire logic        i_other_done,
    input  wire logic [7:0]  i_other_code,
    input  wire logic        i_other_has_sense,
    input  wire logic [19:0] i_other_triplet,
    input  wire logic        i_other_queued,
    input  wire logic        i_command_abort_state,
    // Identify words and feature enable.
    input  wire logic [15:0] i_ident_word_119,
    input  wire logic [15:0] i_ident_word_120,
    input  wire logic        i_sense_feature_enable,
    input  wire logic        i_sense_feature_disable,
    // Servo.
    input  wire logic [15:0] i_cylinder,
    input  wire logic        i_servo_fail,
    output logic             o_seek_home,
    // Task file outputs.
    output logic [7:0]       o_sector_number,
    output logic [7:0]       o_cylinder_low,
    output logic [7:0]       o_cylinder_high,
    output logic [7:0]       o_command_error_flags,
    output logic [7:0]       o_command_status_flags,
    output logic             o_cmd_done,
    output logic             o_log_sense_invalid,
    output logic             o_sense_feature_on
);
    typedef struct packed {
        shsr_pkg::shsr_state_t state;
        logic [31:0]           timer;
        logic [19:0]           triplet;
        logic [19:0]           queued_triplet;
        logic                  queued_valid;
        logic                  feature_on;
        logic [7:0]            sector_number;
        logic [7:0]            cylinder_low;
        logic [7:0]            cylinder_high;
        logic [7:0]            err;
        logic [7:0]            sts;
        logic                  done;
    } shsr_core_t;

    shsr_core_t st_reg;
    shsr_core_t st_next;
    logic       pending;
    logic       pend_set;
    logic       pend_clr;
    logic       log_set;
    logic       log_clr;
    logic       ident_ok;
    logic       sense_cmd;
    logic       home_cmd;
    logic       other_updates;

    assign ident_ok  = i_ident_word_119[shsr_pkg::IDENT_SENSE_BIT]
                     & i_ident_word_120[shsr_pkg::IDENT_SENSE_BIT]; // see R12
    assign sense_cmd = i_cmd_valid && (i_cmd_code == shsr_pkg::CMD_SENSE_REPORT)
                     && (st_reg.state == shsr_pkg::SHSR_IDLE);
    assign home_cmd  = i_cmd_valid && (i_cmd_code[7:4] == shsr_pkg::CMD_HOME_NIBBLE)
                     && (st_reg.state == shsr_pkg::SHSR_IDLE); // see R01
    // C3 leaves the stored triplet as it was.
    assign other_updates = i_other_done
                     && (i_other_code != shsr_pkg::CMD_NO_SENSE_UPDATE); // see R07
    // A new outcome arriving with the report wins, so it is never lost.
    assign pend_set  = other_updates && i_other_has_sense; // see R08
    assign pend_clr  = sense_cmd || (other_updates && !i_other_has_sense); // see R06
    // Non-queued errors leave log sense content; a report spoils it.
    assign log_set   = sense_cmd; // see R11
    assign log_clr   = pend_set && !i_other_queued;

    shsr_flag_hold u_pending (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_set  (pend_set),
        .i_clr  (pend_clr),
        .o_flag (pending)
    );

    shsr_flag_hold u_log_invalid (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_set  (log_set),
        .i_clr  (log_clr),
        .o_flag (o_log_sense_invalid)
    );

    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        // Feature defaults off; enable wins over a same-cycle disable.
        if (i_sense_feature_enable) begin
            st_next.feature_on = 1'b1;
        end else if (i_sense_feature_disable) begin
            st_next.feature_on = 1'b0;
        end
        case (st_reg.state)
            shsr_pkg::SHSR_IDLE: begin
                if (home_cmd) begin
                    st_next.state = shsr_pkg::SHSR_SEEK;
                    st_next.timer = 32'h0000_0000;
                    st_next.err   = shsr_pkg::ERR_RESET;
                    st_next.sts[shsr_pkg::STS_BUSY_BIT]          = 1'b1;
                    st_next.sts[shsr_pkg::STS_SEEK_COMPLETE_BIT] = 1'b0;
                end else if (sense_cmd) begin
                    // Queued setup plays no part in what is returned here.
                    if (pending) begin
                        st_next.sector_number = st_reg.triplet[7:0]; // see R04
                        st_next.cylinder_low  = st_reg.triplet[15:8]; // see R04
                        st_next.cylinder_high = {4'h0, st_reg.triplet[19:16]}; // see R04
                    end else if (st_reg.queued_valid) begin
                        st_next.sector_number = st_reg.queued_triplet[7:0]; // see R10
                        st_next.cylinder_low  = st_reg.queued_triplet[15:8];
                        st_next.cylinder_high = {4'h0, st_reg.queued_triplet[19:16]};
                    end else begin
                        st_next.sector_number = 8'h00; // see R05
                        st_next.cylinder_low  = 8'h00;
                        st_next.cylinder_high = 8'h00;
                    end // see R03 R09
                    st_next.triplet      = shsr_pkg::TRIPLET_RESET; // see R06
                    st_next.queued_valid = 1'b0;
                    st_next.err          = shsr_pkg::ERR_RESET;
                    st_next.sts[shsr_pkg::STS_BUSY_BIT]            = 1'b0; // see R16
                    st_next.sts[shsr_pkg::STS_DEVICE_FAULT_BIT]    = 1'b0;
                    st_next.sts[shsr_pkg::STS_ERROR_BIT]           = 1'b0;
                    st_next.sts[shsr_pkg::STS_SENSE_AVAILABLE_BIT] = 1'b0;
                    st_next.done = 1'b1;
                end
            end
            shsr_pkg::SHSR_SEEK: begin
                st_next.timer = st_reg.timer + 32'h0000_0001;
                if (i_cylinder == shsr_pkg::CYL_ZERO) begin
                    st_next.state = shsr_pkg::SHSR_DONE;
                    st_next.sts[shsr_pkg::STS_SEEK_COMPLETE_BIT] = 1'b1;
                end else if (i_servo_fail || (st_reg.timer >= 32'(SEEK_TIMEOUT - 1))) begin
                    st_next.state = shsr_pkg::SHSR_DONE;
                    st_next.err[shsr_pkg::ERR_TRACK_ZERO_MISSING_BIT] = 1'b1; // see R02
                end
            end
            shsr_pkg::SHSR_DONE: begin
                st_next.state = shsr_pkg::SHSR_IDLE;
                st_next.sts[shsr_pkg::STS_BUSY_BIT]         = 1'b0; // see R16
                st_next.sts[shsr_pkg::STS_DEVICE_FAULT_BIT] = 1'b0;
                // Error and sense-available are independent, so both may stand.
                st_next.sts[shsr_pkg::STS_ERROR_BIT] = |st_reg.err; // see R16 R14
                st_next.done = 1'b1;
            end
            default: begin
                st_next.state = shsr_pkg::SHSR_IDLE;
            end
        endcase
        // Taken after the decode, so an outcome landing with a report is kept.
        if (other_updates) begin
            st_next.triplet = i_other_has_sense ? i_other_triplet
                                                : shsr_pkg::TRIPLET_RESET; // see R08
            // Queued errors keep their own copy, untouched by aborts in abort state.
            if (i_other_queued && i_other_has_sense && !i_command_abort_state) begin
                st_next.queued_triplet = i_other_triplet; // see R10
                st_next.queued_valid   = 1'b1;
            end
            st_next.sts[shsr_pkg::STS_SENSE_AVAILABLE_BIT] =
                i_other_has_sense && ident_ok; // see R12
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg.state          <= shsr_pkg::SHSR_IDLE;
            st_reg.timer          <= 32'h0000_0000;
            st_reg.triplet        <= shsr_pkg::TRIPLET_RESET;
            st_reg.queued_triplet <= shsr_pkg::TRIPLET_RESET;
            st_reg.queued_valid   <= 1'b0;
            st_reg.feature_on     <= 1'b0; // see R15
            st_reg.sector_number  <= 8'h00;
            st_reg.cylinder_low   <= 8'h00;
            st_reg.cylinder_high  <= 8'h00;
            st_reg.err            <= shsr_pkg::ERR_RESET;
            st_reg.sts            <= shsr_pkg::STS_RESET;
            st_reg.done           <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Heads are driven home for the whole seek; the servo owns the motion.
    assign o_seek_home            = (st_reg.state == shsr_pkg::SHSR_SEEK); // see R01
    assign o_sector_number        = st_reg.sector_number;
    assign o_cylinder_low         = st_reg.cylinder_low;
    assign o_cylinder_high        = st_reg.cylinder_high;
    assign o_command_error_flags  = st_reg.err;
    // Host ignores bit 1 when either identify bit is clear; it is driven zero then.
    assign o_command_status_flags = ident_ok ? st_reg.sts
                                  : (st_reg.sts & 8'hFD); // see R13
    assign o_cmd_done             = st_reg.done;
    assign o_sense_feature_on     = st_reg.feature_on;
endmodule // shsr_core

// File: bench/shsr_core_monitor.sv
// Concurrent checks for the home-seek and sense-report block.
// Assumes it is bound to shsr_core and sees only that module's ports.
`timescale 1ns/100ps
module shsr_core_monitor (
    // Clock and reset.
    input wire logic        i_clk,
    input wire logic        i_rst,
    // Inputs watched.
    input wire logic        i_cmd_valid,
    input wire logic [7:0]  i_cmd_code,
    input wire logic        i_other_done,
    input wire logic [7:0]  i_other_code,
    input wire logic        i_other_has_sense,
    input wire logic [15:0] i_ident_word_119,
    input wire logic [15:0] i_ident_word_120,
    input wire logic        i_sense_feature_enable,
    input wire logic        i_servo_fail,
    // Outputs watched.
    input wire logic        o_seek_home,
    input wire logic [7:0]  o_cylinder_high,
    input wire logic [7:0]  o_command_error_flags,
    input wire logic [7:0]  o_command_status_flags,
    input wire logic        o_cmd_done,
    input wire logic        o_sense_feature_on
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Busy also covers the done cycle, so it marks when a command may be taken.
    logic take_s;
    logic take_h;
    assign take_s = i_cmd_valid && !o_command_status_flags[7]
                    && i_cmd_code == shsr_pkg::CMD_SENSE_REPORT;
    assign take_h = i_cmd_valid && !o_command_status_flags[7]
                    && i_cmd_code[7:4] == shsr_pkg::CMD_HOME_NIBBLE;
    a_sense_answer: assert property (take_s |=> o_cmd_done)
        else $error("sense report not answered next cycle");
    a_sense_fields: assert property (take_s && !i_other_done
        |=> o_cylinder_high[7:4] == 4'h0
        && o_command_error_flags == 8'h00 && !o_command_status_flags[1])
        else $error("sense report fields wrong");
    a_home_start: assert property (take_h |=> o_seek_home && o_command_status_flags[7])
        else $error("home seek did not start");
    a_home_finish: assert property ($fell(o_seek_home) |=> o_cmd_done)
        else $error("home seek did not complete");
    a_seek_fail: assert property (o_seek_home && i_servo_fail
        |-> ##[1:3] (o_cmd_done && o_command_error_flags[1]))
        else $error("failed seek did not flag track zero");
    a_done_status: assert property (o_cmd_done |-> !o_command_status_flags[7]
        && !o_command_status_flags[5]
        && o_command_status_flags[0] == |o_command_error_flags)
        else $error("completion status wrong");
    a_avail_mask: assert property (!(i_ident_word_119[shsr_pkg::IDENT_SENSE_BIT]
        && i_ident_word_120[shsr_pkg::IDENT_SENSE_BIT]) |-> !o_command_status_flags[1])
        else $error("sense available shown while unsupported");
    a_avail_set: assert property (i_other_done && i_other_has_sense
        && i_other_code != shsr_pkg::CMD_NO_SENSE_UPDATE
        && i_ident_word_119[shsr_pkg::IDENT_SENSE_BIT]
        && i_ident_word_120[shsr_pkg::IDENT_SENSE_BIT] |=> o_command_status_flags[1])
        else $error("sense available not set after sense data");
    a_feat_reset: assert property ($fell(i_rst) |-> !o_sense_feature_on)
        else $error("sense feature on after reset");
    a_feat_enable: assert property (i_sense_feature_enable |=> o_sense_feature_on)
        else $error("sense feature not enabled");
    c_sense: cover property (take_s);
    c_home: cover property (take_h);
    c_fail: cover property (o_cmd_done && o_command_error_flags[1]);
endmodule // shsr_core_monitor

bind shsr_core shsr_core_monitor u_mon (
    .i_clk                  (i_clk),
    .i_rst                  (i_rst),
    .i_cmd_valid            (i_cmd_valid),
    .i_cmd_code             (i_cmd_code),
    .i_other_done           (i_other_done),
    .i_other_code           (i_other_code),
    .i_other_has_sense      (i_other_has_sense),
    .i_ident_word_119       (i_ident_word_119),
    .i_ident_word_120       (i_ident_word_120),
    .i_sense_feature_enable (i_sense_feature_enable),
    .i_servo_fail           (i_servo_fail),
    .o_seek_home            (o_seek_home),
    .o_cylinder_high        (o_cylinder_high),
    .o_command_error_flags  (o_command_error_flags),
    .o_command_status_flags (o_command_status_flags),
    .o_cmd_done             (o_cmd_done),
    .o_sense_feature_on     (o_sense_feature_on)
);

// File: bench/shsr_servo_model.sv
// Head positioner model: steps one cylinder a cycle toward zero while seeking.
// Assumes the bench loads a start cylinder before any seek; stall models a servo fault.
`timescale 1ns/100ps
module shsr_servo_model (
    // Clock and control.
    input  wire logic        i_clk,
    input  wire logic        i_load,
    input  wire logic [15:0] i_start,
    input  wire logic        i_stall,
    input  wire logic        i_seek_home,
    // Position.
    output logic [15:0]      o_cylinder
);
    always_ff @(posedge i_clk) begin
        if (i_load) begin
            o_cylinder <= i_start;
        end else if (i_seek_home && !i_stall && o_cylinder != 16'h0000) begin
            o_cylinder <= o_cylinder - 16'h0001;
        end
    end
endmodule // shsr_servo_model

// File: bench/seek_home_and_sense_report_tb_top.sv
// Self-checking bench for the home-seek and sense-report block.
// Assumes shsr_core, its package and the servo model are compiled first.
`timescale 1ns/100ps
module seek_home_and_sense_report_tb_top;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_cmd_valid = 1'b0, i_other_done = 1'b0;
    logic        i_other_has_sense = 1'b0, i_other_queued = 1'b0, i_command_abort_state = 1'b0;
    logic        i_sense_feature_enable = 1'b0, i_sense_feature_disable = 1'b0;
    logic        i_servo_fail = 1'b0, i_load = 1'b1;
    logic [7:0]  i_cmd_code = 8'h00, i_other_code = 8'h00;
    logic [19:0] i_other_triplet = 20'h0_0000, t;
    logic [15:0] i_ident_word_119 = 16'h0040, i_ident_word_120 = 16'h0040;
    logic [15:0] i_start = 16'h0005, i_cylinder, rnd = 16'h005A;
    logic        o_seek_home, o_cmd_done, o_log_sense_invalid, o_sense_feature_on;
    logic [7:0]  o_sector_number, o_cylinder_low, o_cylinder_high;
    logic [7:0]  o_command_error_flags, o_command_status_flags;
    int          fail_count = 0, check_count = 0;

    shsr_core #(.SEEK_TIMEOUT(20)) u_dut (.*);
    shsr_servo_model u_servo (.i_clk(i_clk), .i_load(i_load), .i_start(i_start),
        .i_stall(i_servo_fail), .i_seek_home(o_seek_home), .o_cylinder(i_cylinder));

    initial forever #20 i_clk = ~i_clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Key, code and qualifier as the three response bytes show them.
    function automatic logic [23:0] resp(input logic [19:0] k);
        return {4'h0, k};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Waits are bounded so a stuck command ends the run instead of hanging it.
    task automatic cmd(input logic [7:0] c);
        int n = 0;
        @(posedge i_clk); i_cmd_valid <= 1'b1; i_cmd_code <= c;
        @(posedge i_clk); i_cmd_valid <= 1'b0; #1;
        while (o_cmd_done !== 1'b1) begin
            if (++n > 60) begin fail_count++; close_out(); end
            @(posedge i_clk); #1;
        end
    endtask
    task automatic oth(input logic [7:0] c, input logic h, input logic [19:0] k);
        @(posedge i_clk);
        i_other_done <= 1'b1; i_other_code <= c; i_other_has_sense <= h; i_other_triplet <= k;
        @(posedge i_clk); i_other_done <= 1'b0; #1;
    endtask
    task automatic rpt(input logic [19:0] k);
        cmd(shsr_pkg::CMD_SENSE_REPORT);
        chk({o_cylinder_high, o_cylinder_low, o_sector_number}, resp(k));
    endtask

    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0; i_load <= 1'b0; #1;
        chk(o_command_status_flags, shsr_pkg::STS_RESET);
        chk(o_sense_feature_on, 1'b0);
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd); t = {rnd[3:0], rnd};
            oth(8'h25, 1'b1, t); chk(o_command_status_flags[1], 1'b1);
            chk(o_log_sense_invalid, 1'b0);
            oth(shsr_pkg::CMD_NO_SENSE_UPDATE, 1'b1, ~t);
            rpt(t);
            chk(o_log_sense_invalid, 1'b1);
            rpt(20'h0_0000);
        end
        oth(8'h25, 1'b1, t); oth(8'h30, 1'b0, 20'h0_0000);
        rpt(20'h0_0000);
        @(posedge i_clk); i_other_queued <= 1'b1;
        oth(8'h25, 1'b1, t);
        @(posedge i_clk); i_command_abort_state <= 1'b1;
        oth(8'h25, 1'b1, ~t); oth(8'h30, 1'b0, 20'h0_0000);
        @(posedge i_clk); i_other_queued <= 1'b0; i_command_abort_state <= 1'b0;
        rpt(t);
        $display("sense report tests done");
        @(posedge i_clk); i_ident_word_120 <= 16'h0000;
        oth(8'h25, 1'b1, t); chk(o_command_status_flags[1], 1'b0);
        rpt(t);
        @(posedge i_clk); i_sense_feature_enable <= 1'b1; i_sense_feature_disable <= 1'b1;
        @(posedge i_clk); i_sense_feature_enable <= 1'b0; i_sense_feature_disable <= 1'b0; #1;
        chk(o_sense_feature_on, 1'b1);
        @(posedge i_clk); i_sense_feature_disable <= 1'b1;
        @(posedge i_clk); i_sense_feature_disable <= 1'b0; #1;
        chk(o_sense_feature_on, 1'b0);
        $display("sense feature tests done");
        cmd(8'h1F); chk(i_cylinder, 16'h0000);
        chk(o_command_error_flags, 8'h00); chk(o_command_status_flags[0], 1'b0);
        @(posedge i_clk); i_servo_fail <= 1'b1; i_load <= 1'b1; i_start <= 16'h0007;
        @(posedge i_clk); i_load <= 1'b0;
        cmd(8'h10); chk(o_command_error_flags[1], 1'b1);
        chk(o_command_status_flags[0], 1'b1);
        @(posedge i_clk); i_servo_fail <= 1'b0;
        $display("home seek tests done");
        close_out();
    end
endmodule // seek_home_and_sense_report_tb_top
